// File: hw/avic_pkg.sv
/*
  Package for the vectored interrupt source control block.
  Holds register offsets, mode field layout, encodings and the bus carrier.
  Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
package avic_pkg;

  // Number of sources served by the controller.
  localparam int NumSrc = 32;
  // Width of one source number.
  localparam int SrcW = 5;
  // Width of the priority field.
  localparam int PrioW = 3;
  // Bus data and address widths.
  localparam int DatW = 32;
  localparam int AdrW = 12;

  // Fixed source positions.
  localparam int SrcFast = 0;
  localparam int SrcSys = 1;
  localparam int SrcPerFirst = 2;

  // Register byte offsets.
  localparam logic [AdrW-1:0] OffModeBase = 12'h000;
  localparam logic [AdrW-1:0] OffVecBase = 12'h080;
  localparam logic [AdrW-1:0] OffVector = 12'h100;
  localparam logic [AdrW-1:0] OffFastVector = 12'h104;
  localparam logic [AdrW-1:0] OffCurNum = 12'h108;
  localparam logic [AdrW-1:0] OffPending = 12'h10c;
  localparam logic [AdrW-1:0] OffMask = 12'h110;
  localparam logic [AdrW-1:0] OffCoreLine = 12'h114;
  localparam logic [AdrW-1:0] OffEnable = 12'h120;
  localparam logic [AdrW-1:0] OffDisable = 12'h124;
  localparam logic [AdrW-1:0] OffClear = 12'h128;
  localparam logic [AdrW-1:0] OffSet = 12'h12c;
  localparam logic [AdrW-1:0] OffEndInt = 12'h130;
  localparam logic [AdrW-1:0] OffDebug = 12'h138;
  localparam logic [AdrW-1:0] OffFastEn = 12'h140;
  localparam logic [AdrW-1:0] OffFastDis = 12'h144;
  localparam logic [AdrW-1:0] OffFastSts = 12'h148;

  // Mode register field positions.
  localparam int ModePrioLsb = 0;
  localparam int ModeTrigLsb = 5;
  // Bit of the debug register that holds the general mask.
  localparam int DbgGmskBit = 1;
  // Bit positions in the core line status word.
  localparam int CoreNormBit = 1;
  localparam int CoreFastBit = 0;

  // Trigger conditions; internal sources use bit 0 only (0 level, 1 edge).
  typedef enum logic [1:0]
  {
    TRIG_LOW_LEVEL = 2'h0,
    TRIG_FALL_EDGE = 2'h1,
    TRIG_HIGH_LEVEL = 2'h2,
    TRIG_RISE_EDGE = 2'h3
  } avic_trig_t;

  // Reset values.
  localparam logic [DatW-1:0] ZeroWord = 32'h0000_0000;
  localparam logic [PrioW-1:0] ZeroPrio = 3'h0;
  localparam logic [SrcW-1:0] ZeroSrc = 5'h00;

  // One bus request as seen by the slave.
  typedef struct packed
  {
    logic cyc;
    logic stb;
    logic we;
    logic [AdrW-1:0] adr;
    logic [3:0] sel;
    logic [DatW-1:0] dat;
  } avic_wbreq_t;

endpackage

// File: hw/avic_source_ctrl.sv
/*
  Source control front end of a 32-source vectored interrupt controller.
  Qualifies each source, keeps pending, mask and fast redirection state,
  picks the current interrupt on a vector read and drives the normal and
  fast request lines of the processor core plus an idle wake line.
  Assumes one free-running clock, a classic Wishbone master on the same
  clock, peripheral lines on that clock and interrupt pins from outside.
*/
`timescale 1ns/10ps

module avic_source_ctrl
#(
  parameter int SysLines = 4,
  parameter logic [31:0] ExtSrcMask = 32'h0000_0001,
  parameter bit HasFastPin = 1'b1
)
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Interrupt inputs.
  input wire logic fastInterruptInput,
  input wire logic [31:0] externalInterruptInputs,
  input wire logic [31:0] peripheralIrq,
  input wire logic [SysLines-1:0] systemIrq,
  // Processor core side.
  output logic normalRequestOut_n,
  output logic fastRequestOut_n,
  output logic coreWake
);

  localparam int N = avic_pkg::NumSrc;

  // Refuse sizes that the logic cannot serve.
  if (SysLines < 1)
  begin : g_bad_sys
    $error("SysLines must be at least one");
  end

  // Bus request gathered into one carrier.
  avic_pkg::avic_wbreq_t req;
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                 sel: wb_sel_i, dat: wb_dat_i};

  // A new access is taken in the cycle before ack is given.
  logic access;
  assign access = req.cyc && req.stb && !wb_ack_o;
  logic wrAcc;
  logic rdAcc;
  assign wrAcc = access && req.we;
  assign rdAcc = access && !req.we;

  // Byte-enable mask for stored words.
  logic [31:0] selMask;
  assign selMask = {{8{req.sel[3]}}, {8{req.sel[2]}}, {8{req.sel[1]}}, {8{req.sel[0]}}};
  logic [31:0] wrBits;
  assign wrBits = req.dat & selMask;

  // Word index inside the mode and vector tables.
  logic [avic_pkg::SrcW-1:0] tblIdx;
  assign tblIdx = req.adr[avic_pkg::SrcW+1:2];
  logic isMode;
  logic isVec;
  assign isMode = (req.adr[11:7] == avic_pkg::OffModeBase[11:7]);
  assign isVec = (req.adr[11:7] == avic_pkg::OffVecBase[11:7]);

  // Command strobes, one cycle each.
  logic wrEnable;
  logic wrDisable;
  logic wrSet;
  logic wrClear;
  logic wrEndInt;
  logic rdVector;
  logic rdFastVector;
  assign wrEnable = wrAcc && (req.adr == avic_pkg::OffEnable);
  assign wrDisable = wrAcc && (req.adr == avic_pkg::OffDisable);
  assign wrSet = wrAcc && (req.adr == avic_pkg::OffSet);
  assign wrClear = wrAcc && (req.adr == avic_pkg::OffClear);
  assign wrEndInt = wrAcc && (req.adr == avic_pkg::OffEndInt);
  assign rdVector = rdAcc && (req.adr == avic_pkg::OffVector);
  assign rdFastVector = rdAcc && (req.adr == avic_pkg::OffFastVector);

  // Per-source state and the general mask.
  logic [2:0] prio_r [N];            // Priority field per source.
  avic_pkg::avic_trig_t trig_r [N];  // Trigger condition per source.
  logic [31:0] vector_r [N];         // Handler address per source.
  logic [N-1:0] mask_r;              // Enabled sources.
  logic [N-1:0] fastForce_r;         // Sources redirected to the fast line.
  logic [N-1:0] pend_r;              // Pending sources.
  logic gmsk_r;                      // General mask of the normal line.

  // Arbitration state.
  logic inService_r;                 // A normal interrupt is being handled.
  logic [2:0] curLevel_r;            // Priority of the current interrupt.
  logic [avic_pkg::SrcW-1:0] curNum_r;
  logic [N-1:0] autoClr;             // One-cycle clear from vector reads.

  // Input stages: pins pass two flip-flops, same-clock lines pass none.
  logic [N-1:0] pinMeta_r;
  logic [N-1:0] pinSync_r;
  logic [N-1:0] srcNow;
  logic [N-1:0] srcPrev_r;
  logic [N-1:0] pinIn;

  // Pin vector: source zero is the fast pin, the rest external lines.
  always_comb
  begin
    pinIn = externalInterruptInputs;
    pinIn[avic_pkg::SrcFast] = HasFastPin ? fastInterruptInput : 1'b0;
  end

  // Two-flop resynchroniser on all pin inputs.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
    end
    else
    begin
      pinMeta_r <= pinIn;
      pinSync_r <= pinMeta_r;
    end
  end

  // Source assignment and qualification, one slice per source.
  logic [N-1:0] edgeSrc;
  logic [N-1:0] levelHit;
  logic [N-1:0] edgeHit;
  for (genvar i = 0; i < N; i++)
  begin : g_src
    localparam bit IsExt = (i == avic_pkg::SrcFast) || ExtSrcMask[i];
    // Source numbers line up with peripheral identifiers.
    if (i == avic_pkg::SrcFast)
    begin : g_fast
      assign srcNow[i] = pinSync_r[i];
    end
    else if (i == avic_pkg::SrcSys)
    begin : g_sys
      assign srcNow[i] = |systemIrq;
    end
    else if (IsExt)
    begin : g_ext
      // Muxed or direct pins take the same two-flop path.
      assign srcNow[i] = pinSync_r[i];
    end
    else
    begin : g_int
      assign srcNow[i] = peripheralIrq[i];
    end

    // Edge modes have bit 0 set in the trigger code.
    assign edgeSrc[i] = trig_r[i][0];
    if (IsExt)
    begin : g_q_ext
      // Four conditions on external lines.
      always_comb
      begin
        levelHit[i] = (trig_r[i] == avic_pkg::TRIG_HIGH_LEVEL) ? srcNow[i] : !srcNow[i];
        edgeHit[i] = (trig_r[i] == avic_pkg::TRIG_RISE_EDGE) ?
                     (srcNow[i] && !srcPrev_r[i]) : (!srcNow[i] && srcPrev_r[i]);
      end
    end
    else
    begin : g_q_int
      // Internal lines are active high; polarity is hidden from software.
      always_comb
      begin
        levelHit[i] = srcNow[i];
        edgeHit[i] = srcNow[i] && !srcPrev_r[i];
      end
    end
  end

  // Previous sample for edge detection.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      srcPrev_r <= '0;
    end
    else
    begin
      srcPrev_r <= srcNow;
    end
  end

  // Pending state: edges latch, levels follow; set beats clear.
  logic [N-1:0] swSet;
  logic [N-1:0] swClr;
  assign swSet = wrSet ? wrBits : '0;
  assign swClr = wrClear ? wrBits : '0;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pend_r <= '0;
    end
    else
    begin
      for (int k = 0; k < N; k++)
      begin
        if (!edgeSrc[k])
        begin
          // Level sources ignore set and clear commands.
          pend_r[k] <= levelHit[k];
        end
        else if (edgeHit[k] || swSet[k])
        begin
          pend_r[k] <= 1'b1;
        end
        else if (swClr[k] || autoClr[k])
        begin
          pend_r[k] <= 1'b0;
        end
      end
    end
  end

  // Mask and fast redirection, each changed by an enable and a disable command write.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      mask_r <= '0;
      fastForce_r <= '0;
    end
    else
    begin
      if (wrEnable)
      begin
        mask_r <= mask_r | wrBits;
      end
      else if (wrDisable)
      begin
        mask_r <= mask_r & ~wrBits;
      end
      if (wrAcc && (req.adr == avic_pkg::OffFastEn))
      begin
        fastForce_r <= fastForce_r | wrBits;
      end
      else if (wrAcc && (req.adr == avic_pkg::OffFastDis))
      begin
        fastForce_r <= fastForce_r & ~wrBits;
      end
    end
  end

  // Mode, vector and general mask storage.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      gmsk_r <= 1'b0;
      for (int k = 0; k < N; k++)
      begin
        prio_r[k] <= avic_pkg::ZeroPrio;
        trig_r[k] <= avic_pkg::TRIG_LOW_LEVEL;
        vector_r[k] <= avic_pkg::ZeroWord;
      end
    end
    else if (wrAcc)
    begin
      if (isMode && req.sel[0])
      begin
        prio_r[tblIdx] <= req.dat[avic_pkg::ModePrioLsb +: 3];
        trig_r[tblIdx] <= avic_pkg::avic_trig_t'(req.dat[avic_pkg::ModeTrigLsb +: 2]);
      end
      if (isVec)
      begin
        vector_r[tblIdx] <= (vector_r[tblIdx] & ~selMask) | wrBits;
      end
      if ((req.adr == avic_pkg::OffDebug) && req.sel[0])
      begin
        gmsk_r <= req.dat[avic_pkg::DbgGmskBit];
      end
    end
  end

  // Candidates: pending and enabled; disabled ones drop out entirely.
  logic [N-1:0] active;
  logic [N-1:0] normalCand;
  assign active = pend_r & mask_r;
  assign normalCand = active & ~fastForce_r & ~(32'h1 << avic_pkg::SrcFast);

  // Highest priority candidate; ties go to the lowest number.
  logic winFound;
  logic [2:0] winLevel;
  logic [avic_pkg::SrcW-1:0] winNum;
  always_comb
  begin
    winFound = 1'b0;
    winLevel = avic_pkg::ZeroPrio;
    winNum = avic_pkg::ZeroSrc;
    for (int k = N - 1; k >= 0; k--)
    begin
      if (normalCand[k] && (!winFound || prio_r[k] >= winLevel))
      begin
        winFound = 1'b1;
        winLevel = prio_r[k];
        winNum = avic_pkg::SrcW'(k);
      end
    end
  end

  // Normal line wants service: any candidate when none is in service, else only a higher one.
  logic irqWant;
  assign irqWant = winFound && (!inService_r || (winLevel > curLevel_r));

  // Current interrupt tracking; a vector read takes the winner.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      inService_r <= 1'b0;
      curLevel_r <= avic_pkg::ZeroPrio;
      curNum_r <= avic_pkg::ZeroSrc;
    end
    else if (rdVector && irqWant)
    begin
      inService_r <= 1'b1;
      curLevel_r <= winLevel;
      curNum_r <= winNum;
    end
    else if (wrEndInt)
    begin
      inService_r <= 1'b0;
    end
  end

  // Automatic clears from vector reads.
  always_comb
  begin
    autoClr = '0;
    if (rdVector && irqWant && !fastForce_r[winNum])
    begin
      autoClr[winNum] = 1'b1;
    end
    if (rdFastVector)
    begin
      autoClr[avic_pkg::SrcFast] = 1'b1;
    end
  end

  // Fast line: source zero or any redirected source.
  logic fiqWant;
  assign fiqWant = active[avic_pkg::SrcFast] || |(active & fastForce_r);

  // Request, wake and core line outputs, never gated by power settings.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      normalRequestOut_n <= 1'b1;
      fastRequestOut_n <= 1'b1;
      coreWake <= 1'b0;
    end
    else
    begin
      // A vector read drops the normal line whether or not it is used.
      normalRequestOut_n <= !(irqWant && !gmsk_r && !rdVector);
      fastRequestOut_n <= !fiqWant;
      coreWake <= irqWant || fiqWant;
    end
  end

  // Read multiplexer.
  logic [31:0] rdData;
  always_comb
  begin
    rdData = avic_pkg::ZeroWord;
    if (isMode)
    begin
      rdData[avic_pkg::ModePrioLsb +: 3] = prio_r[tblIdx];
      rdData[avic_pkg::ModeTrigLsb +: 2] = trig_r[tblIdx];
    end
    else if (isVec)
    begin
      rdData = vector_r[tblIdx];
    end
    else
    begin
      case (req.adr)
        avic_pkg::OffVector: rdData = irqWant ? vector_r[winNum] : avic_pkg::ZeroWord;
        avic_pkg::OffFastVector: rdData = vector_r[avic_pkg::SrcFast];
        avic_pkg::OffCurNum: rdData[avic_pkg::SrcW-1:0] = curNum_r;
        avic_pkg::OffPending: rdData = pend_r;
        avic_pkg::OffMask: rdData = mask_r;
        avic_pkg::OffCoreLine:
        begin
          rdData[avic_pkg::CoreNormBit] = !normalRequestOut_n;
          rdData[avic_pkg::CoreFastBit] = !fastRequestOut_n;
        end
        avic_pkg::OffDebug: rdData[avic_pkg::DbgGmskBit] = gmsk_r;
        avic_pkg::OffFastSts: rdData = fastForce_r;
        default: rdData = avic_pkg::ZeroWord;
      endcase
    end
  end

  // Bus answer: ack one cycle after the request, dropped the next cycle.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= avic_pkg::ZeroWord;
    end
    else
    begin
      wb_ack_o <= access;
      wb_dat_o <= rdAcc ? rdData : avic_pkg::ZeroWord;
    end
  end

endmodule

// File: tb/avic_source_ctrl_properties.sv
/*
  Concurrent checks on the ports of the interrupt source control block.
  Assumes one clock, a synchronous active-low reset and a classic Wishbone master.
*/
`timescale 1ns/10ps
module avic_source_ctrl_properties
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Processor core side.
  input wire logic normalRequestOut_n,
  input wire logic fastRequestOut_n,
  input wire logic coreWake
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // High on an edge where the slave accepts a request.
  logic take;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // A read of one register accepted on this edge.
  sequence s_rd(logic [11:0] a);
    take && !wb_we_i && wb_adr_i == a;
  endsequence
  // Both request lines unchanged over one edge.
  sequence s_lines_held;
    $stable(normalRequestOut_n) && $stable(fastRequestOut_n);
  endsequence
  a_ack_after_take: assert property (take |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(take))
    else $error("ack without request");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  a_wake_on_req: assert property (!normalRequestOut_n || !fastRequestOut_n |-> coreWake)
    else $error("request line without wake");
  a_vec_read_release: assert property (s_rd(avic_pkg::OffVector) |=> normalRequestOut_n)
    else $error("normal line still low after vector read");
  a_core_line_image: assert property (s_rd(avic_pkg::OffCoreLine) ##1 s_lines_held |->
    wb_dat_o == {30'h0, !normalRequestOut_n, !fastRequestOut_n})
    else $error("core line image wrong");
  a_cur_num_width: assert property (s_rd(avic_pkg::OffCurNum) |=> wb_dat_o[31:5] == 27'h0)
    else $error("current number too wide");
endmodule

// File: tb/avic_core_model.sv
/*
  Behavioural processor core beside the controller's request outputs.
  Assumes the wake line is a registered level on the same clock.
*/
`timescale 1ns/10ps
module avic_core_model
(
  // Clock.
  input wire logic sys_clk,
  // Controller outputs.
  input wire logic normalRequestOut_n,
  input wire logic fastRequestOut_n,
  input wire logic coreWake,
  // Sleep request and idle state.
  input wire logic goIdle,
  output logic coreIdle
);
  // The core enters idle on request and leaves it when woken.
  initial coreIdle = 1'b0;
  always @(posedge sys_clk)
    if (coreWake === 1'b1)
      coreIdle <= 1'b0;
    else if (goIdle === 1'b1)
      coreIdle <= 1'b1;
endmodule

// File: tb/avic_source_ctrl_tb_top.sv
/*
  Self-checking bench for the interrupt source control block.
  Assumes the bus answers with a one-cycle ack and source 10 is external.
*/
`timescale 1ns/10ps
module avic_source_ctrl_tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  avic_pkg::avic_wbreq_t req = '0;
  logic [31:0] datO;
  logic ack;
  logic fastPin = 1'b1;
  logic [31:0] extPins = 32'h0000_0400;
  logic [31:0] perIrq = 32'h0000_0000;
  logic [3:0] sysIrq = 4'h0;
  logic normN;
  logic fastN;
  logic wake;
  logic goIdle = 1'b0;
  logic coreIdle;
  logic [31:0] rv;
  int errors = 0;
  int nChecks = 0;

  // Free-running 100 MHz clock.
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  avic_source_ctrl #(.ExtSrcMask(32'h0000_0401)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
    .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_adr_i(req.adr),
    .wb_sel_i(req.sel), .wb_dat_i(req.dat), .wb_dat_o(datO), .wb_ack_o(ack),
    .fastInterruptInput(fastPin), .externalInterruptInputs(extPins),
    .peripheralIrq(perIrq), .systemIrq(sysIrq), .normalRequestOut_n(normN),
    .fastRequestOut_n(fastN), .coreWake(wake));

  avic_core_model core (.sys_clk(sys_clk), .normalRequestOut_n(normN),
    .fastRequestOut_n(fastN), .coreWake(wake), .goIdle(goIdle), .coreIdle(coreIdle));

  // Prints the verdict and stops.
  task automatic complete_run();
    if (errors == 0 && nChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // One classic Wishbone cycle; ack and read data are taken at the rising edge
  // where ack is sampled high, and the request is released at that same edge.
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1)
    begin
      errors++;
      complete_run();
    end
    q = datO;
    req <= '0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, rv);
    chk($sformatf("reg %h", a), rv, e);
  endtask

  task automatic mode(input int n, input logic [31:0] v);
    wr(12'(avic_pkg::OffModeBase + 4 * n), v);
  endtask

  task automatic vec(input int n, input logic [31:0] v);
    wr(12'(avic_pkg::OffVecBase + 4 * n), v);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Main sequence.
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk("lines", {29'h0, wake, normN, fastN}, 32'h3);
    // Pin synchronisers start low, so low-level pins read pending until they settle.
    settle(3);
    rdc(avic_pkg::OffPending, 32'h0);
    // Mask commands.
    wr(avic_pkg::OffEnable, 32'h0000_0305);
    rdc(avic_pkg::OffMask, 32'h0000_0305);
    wr(avic_pkg::OffDisable, 32'hffff_ffff);
    rdc(avic_pkg::OffMask, 32'h0);
    // Internal edge source through a full service.
    mode(2, 32'h0000_0023);
    vec(2, 32'h0000_2000);
    perIrq[2] <= 1'b1;
    settle(3);
    perIrq[2] <= 1'b0;
    goIdle <= 1'b1;
    settle(3);
    goIdle <= 1'b0;
    rdc(avic_pkg::OffPending, 32'h4);
    chk("idle", {31'h0, coreIdle}, 32'h1);
    wr(avic_pkg::OffEnable, 32'h4);
    settle(3);
    chk("norm", {31'h0, normN}, 32'h0);
    chk("idle", {31'h0, coreIdle}, 32'h0);
    rdc(avic_pkg::OffCoreLine, 32'h2);
    rdc(avic_pkg::OffVector, 32'h0000_2000);
    chk("norm", {31'h0, normN}, 32'h1);
    rdc(avic_pkg::OffPending, 32'h0);
    rdc(avic_pkg::OffCurNum, 32'h2);
    wr(avic_pkg::OffEndInt, 32'h0);
    wr(avic_pkg::OffDisable, 32'h4);
    // Priority and equal-priority order.
    mode(3, 32'h0000_0022);
    mode(4, 32'h0000_0022);
    mode(5, 32'h0000_0027);
    vec(3, 32'h0000_3000);
    vec(5, 32'h0000_5000);
    wr(avic_pkg::OffSet, 32'h38);
    wr(avic_pkg::OffEnable, 32'h38);
    settle(3);
    rdc(avic_pkg::OffVector, 32'h0000_5000);
    wr(avic_pkg::OffEndInt, 32'h0);
    rdc(avic_pkg::OffVector, 32'h0000_3000);
    rdc(avic_pkg::OffPending, 32'h10);
    wr(avic_pkg::OffEndInt, 32'h0);
    wr(avic_pkg::OffClear, 32'h10);
    rdc(avic_pkg::OffPending, 32'h0);
    wr(avic_pkg::OffDisable, 32'h38);
    // Level source ignores set and clear.
    wr(avic_pkg::OffSet, 32'h80);
    rdc(avic_pkg::OffPending, 32'h0);
    perIrq[7] <= 1'b1;
    settle(3);
    wr(avic_pkg::OffClear, 32'h80);
    rdc(avic_pkg::OffPending, 32'h80);
    perIrq[7] <= 1'b0;
    settle(3);
    rdc(avic_pkg::OffPending, 32'h0);
    // A disabled higher source does not win.
    mode(8, 32'h0000_0027);
    mode(2, 32'h0000_0021);
    wr(avic_pkg::OffSet, 32'h104);
    wr(avic_pkg::OffEnable, 32'h4);
    settle(3);
    rdc(avic_pkg::OffVector, 32'h0000_2000);
    wr(avic_pkg::OffEndInt, 32'h0);
    wr(avic_pkg::OffClear, 32'h100);
    // System lines are ORed into source 1.
    sysIrq <= 4'h8;
    settle(3);
    rdc(avic_pkg::OffPending, 32'h2);
    sysIrq <= 4'h0;
    settle(3);
    // General mask wakes without the normal line.
    wr(avic_pkg::OffDebug, 32'h2);
    wr(avic_pkg::OffSet, 32'h4);
    settle(3);
    chk("gmask", {30'h0, wake, normN}, 32'h3);
    wr(avic_pkg::OffDebug, 32'h0);
    settle(3);
    chk("norm", {31'h0, normN}, 32'h0);
    rdc(avic_pkg::OffVector, 32'h0000_2000);
    wr(avic_pkg::OffEndInt, 32'h0);
    wr(avic_pkg::OffDisable, 32'h4);
    // Fast pin on source 0, rising edge.
    mode(0, 32'h0000_0060);
    vec(0, 32'h0000_1000);
    fastPin <= 1'b0;
    settle(4);
    wr(avic_pkg::OffClear, 32'h1);
    fastPin <= 1'b1;
    wr(avic_pkg::OffEnable, 32'h1);
    settle(4);
    chk("fast", {30'h0, normN, fastN}, 32'h2);
    rdc(avic_pkg::OffFastVector, 32'h0000_1000);
    rdc(avic_pkg::OffPending, 32'h0);
    wr(avic_pkg::OffDisable, 32'h1);
    // Fast forcing keeps pending across a vector read.
    mode(9, 32'h0000_0027);
    wr(avic_pkg::OffFastEn, 32'h200);
    wr(avic_pkg::OffSet, 32'h200);
    wr(avic_pkg::OffEnable, 32'h200);
    settle(3);
    chk("force", {30'h0, normN, fastN}, 32'h2);
    rdc(avic_pkg::OffVector, 32'h0);
    rdc(avic_pkg::OffPending, 32'h200);
    wr(avic_pkg::OffClear, 32'h200);
    wr(avic_pkg::OffDisable, 32'h200);
    // All four conditions of external source 10; its internal line is ignored.
    perIrq[10] <= 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      extPins[10] <= ~m[1];
      mode(10, 32'(m) << 5);
      settle(4);
      wr(avic_pkg::OffClear, 32'h400);
      rdc(avic_pkg::OffPending, 32'h0);
      extPins[10] <= m[1];
      settle(5);
      rdc(avic_pkg::OffPending, 32'h400);
    end
    rdc(12'h200, 32'h0);
    complete_run();
  end
endmodule

bind avic_source_ctrl avic_source_ctrl_properties u_props (.sys_clk(sys_clk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .normalRequestOut_n(normalRequestOut_n),
  .fastRequestOut_n(fastRequestOut_n), .coreWake(coreWake));
